// [design/udf_delay.sv]
`timescale 1ns/1ns
// one delayed output terminal, timed in tenth-second ticks
module udf_delay
    import udf_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // timing
    input  wire logic              tick,
    input  wire logic [FREQ_W-1:0] delay,
    input  wire logic              close_only,
    // terminal
    input  wire logic              din,
    output logic                   dout
);

    typedef struct packed {
        logic              dout;
        logic              prev;
        logic [FREQ_W-1:0] cnt;
    } udf_dly_s;

    udf_dly_s q;
    udf_dly_s n;

    // count restarts on every change so a glitch never leaks through
    always_comb begin
        n      = q;
        n.prev = din;
        if (din != q.prev || din == q.dout) begin
            n.cnt = '0;
        end else if (close_only && !din) begin
            n.dout = 1'b0;                                 // opening is not delayed
        end else if (q.cnt >= delay) begin
            n.dout = din;
        end else if (tick) begin
            n.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign dout = q.dout;

endmodule : udf_delay

// [design/udf_pkg.sv]
package udf_pkg;

    // timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TENTH_S_NS      = 100_000_000;
    localparam int TICK_CYCLES_DEF = TENTH_S_NS / CLK_PERIOD_NS;
    localparam int PRE_W           = 24;

    // widths and pin positions
    localparam int FREQ_W    = 12;
    localparam int AIN_W     = 10;
    localparam int FUNC_N    = 128;
    localparam int PIN_N     = 5;
    localparam int PIN_UP    = 0;
    localparam int PIN_DOWN  = 1;
    localparam int PIN_CLEAR = 2;
    localparam int PIN_STOP  = 3;
    localparam int PIN_PWR   = 4;

    // codes and modes
    localparam logic [7:0] CODE_OFF   = 8'hfe;
    localparam logic [7:0] CODE_ON    = 8'hff;
    localparam logic [2:0] SRC_UPDOWN = 3'h5;
    localparam logic [2:0] RET_RECORD = 3'h6;
    localparam logic [2:0] RET_NONE   = 3'h7;
    localparam logic [1:0] GRP_PRESET = 2'h0;
    localparam logic [1:0] GRP_ZERO   = 2'h1;

    // analog scaling
    localparam logic [7:0] TRIM_UNITY = 8'h80;
    localparam int         TRIM_SHIFT = 7;
    localparam int         AIN_FULL   = 1023;
    localparam int         PCT_SCALE  = 100;
    localparam logic [6:0] PCT_FULL   = 7'h64;
    localparam logic [6:0] PCT_HALF   = 7'h32;

    // frequencies in tenths of a hertz, RESP_DEF a response time in ticks
    localparam logic [11:0] FREQ_50HZ = 12'h1f4;
    localparam logic [11:0] STEP_DEF  = 12'h001;
    localparam logic [11:0] RESP_DEF  = 12'h001;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DELAY  = 8'h04;
    localparam logic [7:0] ADDR_RSEL   = 8'h08;
    localparam logic [7:0] ADDR_UP     = 8'h0c;
    localparam logic [7:0] ADDR_DOWN   = 8'h10;
    localparam logic [7:0] ADDR_INIT   = 8'h14;
    localparam logic [7:0] ADDR_LIMIT  = 8'h18;
    localparam logic [7:0] ADDR_AIN1   = 8'h1c;
    localparam logic [7:0] ADDR_AIN1_F = 8'h20;
    localparam logic [7:0] ADDR_AIN2   = 8'h24;
    localparam logic [7:0] ADDR_AIN2_F = 8'h28;
    localparam logic [7:0] ADDR_STAT   = 8'h2c;
    localparam logic [7:0] ADDR_AOUT   = 8'h30;
    localparam logic [7:0] ADDR_ORIG   = 8'h34;

    // register layouts
    typedef struct packed {
        logic [8:0] rsv;
        logic [2:0] retention;
        logic [2:0] source;
        logic       combine;
        logic [7:0] sel2;
        logic [7:0] sel1;
    } udf_ctrl_s;

    typedef struct packed {
        logic [3:0]  rsv_h;
        logic [11:0] hi;
        logic [3:0]  rsv_l;
        logic [11:0] lo;
    } udf_pair_s;

    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] bias;
        logic       rsv1;
        logic [6:0] pct2;
        logic       rsv0;
        logic [6:0] pct1;
    } udf_ain_s;

    typedef struct packed {
        logic [10:0] rsv;
        logic        trip_insig;
        logic        trip_sig;
        logic        low_speed;
        logic        relay;
        logic        oc;
        logic [3:0]  rsv2;
        logic [11:0] freq;
    } udf_stat_s;

    // reset images
    localparam udf_ain_s  AIN1_RST = '{gain: TRIM_UNITY, bias: TRIM_UNITY, pct2: PCT_FULL,
                                       default: '0};
    localparam udf_ain_s  AIN2_RST = '{gain: TRIM_UNITY, bias: TRIM_UNITY, pct2: PCT_HALF,
                                       default: '0};
    localparam udf_pair_s AINF_RST = '{hi: FREQ_50HZ, default: '0};
    localparam udf_pair_s UD_RST   = '{hi: STEP_DEF, lo: RESP_DEF, default: '0};
    localparam udf_pair_s LIM_RST  = '{lo: FREQ_50HZ, default: '0};

    // fixed trip class list, bit 1 significant, bit 0 insignificant
    function automatic logic [1:0] udf_trip_class(input logic [7:0] code);
        case (code)
            8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0c, 8'h19, 8'h1f,
            8'h20, 8'h21, 8'h24, 8'h29, 8'h2a, 8'h2b, 8'h2e: udf_trip_class = 2'h2;
            8'h01, 8'h0b, 8'h15, 8'h16, 8'h18:               udf_trip_class = 2'h1;
            default:                                         udf_trip_class = 2'h0;
        endcase
    endfunction : udf_trip_class

endpackage : udf_pkg

// [design/udf_top.sv]
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
// output terminal logic, up/down frequency, analog mapping, low speed
module udf_top
    import udf_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // drive state, same clock
    input  wire logic [FUNC_N-1:0] status_funcs,
    input  wire logic [7:0]        trip_code,
    input  wire logic [FREQ_W-1:0] output_freq,
    input  wire logic [AIN_W-1:0]  analog_input_one,
    input  wire logic [AIN_W-1:0]  analog_input_two,
    // contact pins, asynchronous
    input  wire logic              up_contact,
    input  wire logic              down_contact,
    input  wire logic              clear_contact,
    input  wire logic              stop_reset_contact,
    input  wire logic              power_loss,
    // terminals and results
    output logic                   open_collector_output_one,
    output logic                   relay_one,
    output logic                   low_speed,
    output logic                   trip_significant,
    output logic                   trip_insignificant,
    output logic [FREQ_W-1:0]      updown_frequency,
    output logic [FREQ_W-1:0]      ain1_frequency,
    output logic [FREQ_W-1:0]      ain2_frequency
);

    typedef struct packed {
        logic [PIN_N-1:0]  s1;
        logic [PIN_N-1:0]  s2;
        logic [PIN_N-1:0]  s3;
        logic [PRE_W-1:0]  pre;
        udf_ctrl_s         ctrl;
        udf_pair_s         delay;
        udf_pair_s         rsel;
        udf_pair_s         up;
        udf_pair_s         down;
        udf_pair_s         init;
        udf_pair_s         limit;
        udf_ain_s          ain1;
        udf_pair_s         ain1_f;
        udf_ain_s          ain2;
        udf_pair_s         ain2_f;
        logic [FREQ_W-1:0] orig;
        logic [FREQ_W-1:0] freq;
        logic [FREQ_W-1:0] tmr;
        logic              started;
        logic [FREQ_W-1:0] ain1_out;
        logic [FREQ_W-1:0] ain2_out;
        logic              low_speed;
        logic              trip_sig;
        logic              trip_insig;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } udf_state_s;

    localparam udf_state_s RST_STATE = '{ain1: AIN1_RST, ain2: AIN2_RST, ain1_f: AINF_RST,
                                         ain2_f: AINF_RST, up: UD_RST, down: UD_RST,
                                         limit: LIM_RST, default: '0};

    udf_state_s        q;
    udf_state_s        n;
    logic [1:0]        rst_sync_r;
    logic              rst_n_s;
    logic              tick;
    logic              oc_raw;
    logic              relay_raw;
    logic              oc_out;
    logic              relay_out;
    logic              clr_ev;
    logic              pwr_ev;
    logic              src_ud;
    logic              go_up;
    logic              go_dn;
    logic              hit;
    logic [31:0]       rd;
    logic [FREQ_W-1:0] reload;
    logic [FREQ_W:0]   sum;
    logic [1:0]        tclass;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_r[1];

    // pick one output function; odd codes invert the even one below
    function automatic logic func_pick(input logic [7:0] code, input logic [FUNC_N-1:0] st);
        if (code == CODE_OFF) begin
            func_pick = 1'b0;
        end else if (code == CODE_ON) begin
            func_pick = 1'b1;
        end else begin
            func_pick = st[code[7:1]] ^ code[0];
        end
    endfunction : func_pick

    // trim then map linearly between the two points, result clamped to them
    function automatic logic [FREQ_W-1:0] ain_map(input logic [AIN_W-1:0] raw,
                                                 input udf_ain_s c, input udf_pair_s f);
        logic signed [33:0] adj;
        logic signed [33:0] x;
        logic signed [33:0] x1;
        logic signed [33:0] x2;
        logic signed [33:0] y;
        logic signed [33:0] lo;
        logic signed [33:0] hi;
        adj = ((34'(raw) * 34'(c.gain)) >>> TRIM_SHIFT) + 34'(c.bias)
              - 34'(TRIM_UNITY);
        if (adj < 0) begin
            adj = '0;
        end else if (adj > 34'(AIN_FULL)) begin
            adj = 34'(AIN_FULL);
        end
        x  = adj * 34'(PCT_SCALE);
        x1 = 34'(c.pct1) * 34'(AIN_FULL);
        x2 = 34'(c.pct2) * 34'(AIN_FULL);
        lo = (f.lo < f.hi) ? 34'(f.lo) : 34'(f.hi);
        hi = (f.lo < f.hi) ? 34'(f.hi) : 34'(f.lo);
        if (x2 == x1) begin
            y = 34'(f.lo);
        end else begin
            y = $signed(34'(f.lo)) + ((x - x1) * ($signed(34'(f.hi)) - $signed(34'(f.lo))))
                / (x2 - x1);                               // signed below point 1
        end
        if (y < lo) begin
            y = lo;
        end else if (y > hi) begin
            y = hi;
        end
        ain_map = y[FREQ_W-1:0];
    endfunction : ain_map

    // register read mux and decode
    always_comb begin
        hit = 1'b1;
        rd  = '0;
        case (paddr)
            ADDR_CTRL:   rd = q.ctrl;
            ADDR_DELAY:  rd = q.delay;
            ADDR_RSEL:   rd = q.rsel;
            ADDR_UP:     rd = q.up;
            ADDR_DOWN:   rd = q.down;
            ADDR_INIT:   rd = q.init;
            ADDR_LIMIT:  rd = q.limit;
            ADDR_AIN1:   rd = q.ain1;
            ADDR_AIN1_F: rd = q.ain1_f;
            ADDR_AIN2:   rd = q.ain2;
            ADDR_AIN2_F: rd = q.ain2_f;
            ADDR_STAT:   rd = udf_stat_s'{freq: q.freq, oc: oc_out, relay: relay_out,
                                         low_speed: q.low_speed, trip_sig: q.trip_sig,
                                         trip_insig: q.trip_insig, default: '0};
            ADDR_AOUT:   rd = udf_pair_s'{lo: q.ain1_out, hi: q.ain2_out, default: '0};
            ADDR_ORIG:   rd = 32'(q.orig);
            default:     hit = 1'b0;
        endcase
    end

    // undelayed terminal values
    always_comb begin
        if (q.ctrl.combine) begin
            oc_raw = func_pick(q.ctrl.sel1, status_funcs)
                   | func_pick(q.ctrl.sel2, status_funcs);
        end else begin
            oc_raw = func_pick(q.ctrl.sel1, status_funcs)
                   & func_pick(q.ctrl.sel2, status_funcs);
        end
        relay_raw = func_pick(q.rsel.lo[7:0], status_funcs);
    end

    // contact events, read only from the second sync stage onward
    assign tick   = (q.pre == PRE_W'(TICK_CYCLES - 1));
    assign clr_ev = (q.s2[PIN_CLEAR] & ~q.s3[PIN_CLEAR])
                  | (q.s2[PIN_STOP] & ~q.s3[PIN_STOP]);
    assign pwr_ev = q.s2[PIN_PWR] & ~q.s3[PIN_PWR];
    assign src_ud = (q.ctrl.source == SRC_UPDOWN);
    assign go_up  = src_ud & q.s2[PIN_UP] & ~q.s2[PIN_DOWN];
    assign go_dn  = src_ud & q.s2[PIN_DOWN] & ~q.s2[PIN_UP];
    assign tclass = udf_trip_class(trip_code);

    // reload value depends on the retention group
    always_comb begin
        case (q.ctrl.retention[2:1])
            GRP_PRESET: reload = q.init.hi;                // preset frequency
            GRP_ZERO:   reload = '0;
            default:    reload = q.orig;                   // recorded original
        endcase
    end

    // next state
    always_comb begin
        n    = q;
        sum  = '0;
        n.s1 = {power_loss, stop_reset_contact, clear_contact, down_contact, up_contact};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.pre = tick ? '0 : q.pre + 1'b1;

        // apb: answer one cycle into the access phase, write at the ready edge
        n.pready = 1'b0;
        if (psel && penable && !q.pready) begin
            n.pready  = 1'b1;
            n.prdata  = hit ? rd : '0;
            n.pslverr = ~hit;
        end
        if (psel && penable && q.pready && pwrite && hit) begin
            case (paddr)
                ADDR_CTRL:   n.ctrl   = pwdata;
                ADDR_DELAY:  n.delay  = pwdata;
                ADDR_RSEL:   n.rsel   = pwdata;
                ADDR_UP:     n.up     = pwdata;
                ADDR_DOWN:   n.down   = pwdata;
                ADDR_INIT:   n.init   = pwdata;
                ADDR_LIMIT:  n.limit  = pwdata;
                ADDR_AIN1:   n.ain1   = pwdata;
                ADDR_AIN1_F: n.ain1_f = pwdata;
                ADDR_AIN2:   n.ain2   = pwdata;
                ADDR_AIN2_F: n.ain2_f = pwdata;
                default:     n.pslverr = q.pslverr;
            endcase
        end

        // mode 6 keeps the current initial value as the original
        if (q.ctrl.retention == RET_RECORD) begin
            n.orig = q.init.lo;
        end

        // up/down command; hardware events override a same-cycle write
        if (clr_ev) begin
            n.init.lo = reload;
            n.freq    = reload;
            n.started = 1'b1;
            n.tmr     = '0;
        end else if (pwr_ev && q.ctrl.retention[0] && q.ctrl.retention != RET_NONE) begin
            n.init.lo = q.freq;
        end else if (go_up || go_dn) begin
            n.started = 1'b1;
            if (tick) begin
                if (q.tmr + 1'b1 >= (go_up ? q.up.lo : q.down.lo)) begin
                    n.tmr = '0;                            // one step per response time
                    if (go_up) begin
                        sum    = {1'b0, q.freq} + {1'b0, q.up.hi};
                        n.freq = (sum > {1'b0, q.limit.lo}) ? q.limit.lo
                                                             : sum[FREQ_W-1:0];
                    end else begin
                        n.freq = (q.freq > q.down.hi) ? q.freq - q.down.hi : '0;
                    end
                end else begin
                    n.tmr = q.tmr + 1'b1;
                end
            end
        end else begin
            n.tmr = '0;
            if (!q.started) begin
                n.freq = q.init.lo;
            end
        end
        if (n.freq > q.limit.lo) begin
            n.freq = q.limit.lo;                           // max may be lowered later
        end

        // registered results
        n.low_speed  = (output_freq > q.limit.hi);
        n.trip_sig   = tclass[1];
        n.trip_insig = tclass[0];
        n.ain1_out   = ain_map(analog_input_one, q.ain1, q.ain1_f);
        n.ain2_out   = ain_map(analog_input_two, q.ain2, q.ain2_f);
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            q <= RST_STATE;
        end else begin
            q <= n;
        end
    end

    // delayed terminals: open collector both edges, relay closing only
    udf_delay u_oc_dly (
        .clk        (clk),
        .rst_n      (rst_n_s),
        .tick       (tick),
        .delay      (q.delay.lo),
        .close_only (1'b0),
        .din        (oc_raw),
        .dout       (oc_out)
    );

    udf_delay u_relay_dly (
        .clk        (clk),
        .rst_n      (rst_n_s),
        .tick       (tick),
        .delay      (q.delay.hi),
        .close_only (1'b1),
        .din        (relay_raw),
        .dout       (relay_out)
    );

    // outputs, all from flops
    assign prdata                    = q.prdata;
    assign pready                    = q.pready;
    assign pslverr                   = q.pslverr;
    assign open_collector_output_one = oc_out;
    assign relay_one                 = relay_out;
    assign low_speed                 = q.low_speed;
    assign trip_significant          = q.trip_sig;
    assign trip_insignificant        = q.trip_insig;
    assign updown_frequency          = q.freq;
    assign ain1_frequency            = q.ain1_out;
    assign ain2_frequency            = q.ain2_out;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_s);

    sequence seq_power_drop;
        pwr_ev && !clr_ev && q.ctrl.retention[0] && q.ctrl.retention != RET_NONE;
    endsequence

    chk_and_force: assert property (!q.ctrl.combine && q.ctrl.sel1 == CODE_OFF |-> !oc_raw)
        else $error("and combine ignores forced off");
    chk_or_force: assert property (q.ctrl.combine && q.ctrl.sel2 == CODE_ON |-> oc_raw)
        else $error("or combine ignores forced on");
    chk_oc_follow: assert property ((q.delay.lo == '0 && oc_raw) [*3] |-> oc_out)
        else $error("open collector not following with zero delay");
    chk_relay_hold: assert property ($rose(relay_raw) && !relay_out && q.delay.hi != '0
                                     |-> ##1 !relay_out ##1 !relay_out)
        else $error("relay closed before its delay");
    chk_relay_open: assert property (!relay_raw [*3] |-> !relay_out)
        else $error("relay opening was delayed");
    chk_power_save: assert property (seq_power_drop |=> q.init.lo == $past(q.freq))
        else $error("frequency not saved at power loss");
    chk_clear_zero: assert property (clr_ev && q.ctrl.retention[2:1] == GRP_ZERO
                                     |=> q.freq == '0 && q.init.lo == '0)
        else $error("reset contact did not reload zero");
    chk_freq_clamp: assert property (##1 q.freq <= $past(q.limit.lo))
        else $error("up/down frequency above maximum");
    chk_low_speed: assert property (output_freq > q.limit.hi |=> q.low_speed)
        else $error("low speed signal missing");
    chk_trip_class: assert property (trip_code == 8'h02 |=> q.trip_sig && !q.trip_insig)
        else $error("trip class wrong");
    chk_apb_ready: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");

endmodule : udf_top

// [tb/tb_udf_top.sv]
`timescale 1ns/1ns
module tb_udf_top
    import udf_pkg::*;
;
    logic              clk, resetn, psel, penable, pwrite, er;
    logic [7:0]        paddr, trip_code, s1, s2, rs;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, oc, rly, lsp, tsig, tins, cmb;
    logic [FUNC_N-1:0] sf;
    logic [FREQ_W-1:0] ofq, udf, af1, af2;
    logic [AIN_W-1:0]  a1, a2;
    logic              up_c, dn_c, cl_c, up_k, dn_k, cl_k, st_c, pw_c, st_k, pw_k;
    int                error_cnt, total_checks;
    int                gn, bs;
    udf_top #(.TICK_CYCLES(4)) udf_top_inst (.clk(clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .status_funcs(sf), .trip_code(trip_code), .output_freq(ofq),
        .analog_input_one(a1), .analog_input_two(a2), .up_contact(up_k),
        .down_contact(dn_k), .clear_contact(cl_k), .stop_reset_contact(st_k),
        .power_loss(pw_k), .open_collector_output_one(oc), .relay_one(rly),
        .low_speed(lsp), .trip_significant(tsig), .trip_insignificant(tins),
        .updown_frequency(udf), .ain1_frequency(af1), .ain2_frequency(af2));
    udf_contacts udf_contacts_inst (.clk(clk), .up_cmd(up_c), .down_cmd(dn_c),
        .clear_cmd(cl_c), .stop_cmd(st_c), .power_cmd(pw_c), .up_contact(up_k),
        .down_contact(dn_k), .clear_contact(cl_k), .stop_contact(st_k),
        .power_contact(pw_k));
    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // terminal value of one function code
    function automatic logic fn(input logic [7:0] c);
        fn = (c == 8'hfe) ? 1'b0 : (c == 8'hff) ? 1'b1 : sf[c[7:1]] ^ c[0];
    endfunction : fn
    // expected analog frequency, point frequencies left at 0 and 50.0 Hz
    function automatic int ain_exp(input int raw, input int p1, input int p2, input int b,
                                   input int g);
        int a;
        int y;
        int fh;
        fh = FREQ_50HZ;
        a = raw * g / 128 + b - 128;
        a = (a < 0) ? 0 : (a > AIN_FULL) ? AIN_FULL : a;
        y = (a * PCT_SCALE - p1 * AIN_FULL) * fh / ((p2 - p1) * AIN_FULL);
        ain_exp = (y < 0) ? 0 : (y > fh) ? fh : y;
    endfunction : ain_exp
    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // watchdog, run needs well under a thousand cycles
    initial begin
        wt(6000);
        error_cnt++;
        end_of_test();
    end
    initial begin
        {error_cnt, total_checks} = 0;
        {resetn, psel, penable, pwrite, paddr, pwdata, sf, trip_code} = '0;
        {ofq, a1, a2, up_c, dn_c, cl_c, st_c, pw_c} = '0;
        void'($urandom(32'hce37));
        wt(5);
        resetn <= 1'b1;
        wt(3);
        apb(1'b0, ADDR_LIMIT, 32'h0);
        chk(rd, 32'h0000_01f4);
        apb(1'b0, 8'h3c, 32'h0);
        chk(32'(er), 32'h1);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            sf <= {$urandom, $urandom, $urandom, $urandom};
            s1 = (i == 6) ? 8'hfe : 8'($urandom);
            s2 = (i == 7) ? 8'hff : 8'($urandom);
            rs = 8'($urandom);
            apb(1'b1, ADDR_RSEL, 32'(rs));
            apb(1'b1, ADDR_CTRL, {15'h0, i[0], s2, s1});
            wt(4);
            cmb = i[0] ? (fn(s1) | fn(s2)) : (fn(s1) & fn(s2));
            chk(32'(oc), 32'(cmb));
            chk(32'(rly), 32'(fn(rs)));
        end
        $display("test combine done");
        // three tick delay on both terminals
        apb(1'b1, ADDR_DELAY, 32'h0003_0003);
        apb(1'b1, ADDR_RSEL, 32'h0000_00fe);
        apb(1'b1, ADDR_CTRL, 32'h0000_fefe);
        wt(20);
        apb(1'b1, ADDR_RSEL, 32'h0000_00ff);
        apb(1'b1, ADDR_CTRL, 32'h0000_ffff);
        wt(4);
        chk(32'({oc, rly}), 32'h0);
        wt(20);
        chk(32'({oc, rly}), 32'h3);
        apb(1'b1, ADDR_RSEL, 32'h0000_00fe);
        wt(3);
        chk(32'(rly), 32'h0);
        $display("test delay done");
        apb(1'b1, ADDR_INIT, 32'h0007_0003);
        apb(1'b1, ADDR_LIMIT, 32'h0000_0014);
        wt(3);
        chk(32'(udf), 32'h3);
        apb(1'b1, ADDR_UP, 32'h0005_0001);
        apb(1'b1, ADDR_CTRL, 32'h000a_0000);
        up_c <= 1'b1;
        wt(60);
        chk(32'(udf), 32'h14);
        up_c <= 1'b0;
        cl_c <= 1'b1;
        wt(8);
        cl_c <= 1'b0;
        chk(32'(udf), 32'h7);
        dn_c <= 1'b1;
        wt(60);
        dn_c <= 1'b0;
        chk(32'(udf), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        up_c <= 1'b1;
        wt(20);
        chk(32'(udf), 32'h0);
        $display("test updown done");
        // record 9 as original, climb to max, save it at power loss, then reload
        apb(1'b1, ADDR_INIT, 32'h0000_0009);
        apb(1'b1, ADDR_CTRL, 32'h006a_0000);
        wt(40);
        up_c <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h005a_0000);
        chk(32'(udf), 32'h14);
        pw_c <= 1'b1;
        wt(8);
        pw_c <= 1'b0;
        apb(1'b0, ADDR_INIT, 32'h0);
        chk(rd, 32'h0000_0014);
        st_c <= 1'b1;
        wt(8);
        st_c <= 1'b0;
        chk(32'(udf), 32'h9);
        apb(1'b1, ADDR_CTRL, 32'h002a_0000);
        cl_c <= 1'b1;
        wt(8);
        cl_c <= 1'b0;
        chk(32'(udf), 32'h0);
        $display("test retention done");
        apb(1'b1, ADDR_LIMIT, 32'h0064_01f4);
        gn = $urandom_range(255);
        bs = $urandom_range(255);
        apb(1'b1, ADDR_AIN1, {gn[7:0], bs[7:0], 16'h6414});
        for (int i = 0; i < 6; i++) begin
            ofq <= (i < 2) ? 12'(100 + i) : 12'($urandom_range(200));
            a1 <= (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : 10'($urandom);
            a2 <= 10'($urandom);
            wt(3);
            chk(32'(lsp), 32'(ofq > 100));
            chk(32'(af1), ain_exp(a1, 20, 100, bs, gn));
            chk(32'(af2), ain_exp(a2, 0, 50, 128, 128));
        end
        for (int i = 0; i < 5; i++) begin
            trip_code <= (i < 4) ? 8'(32'h1801_2e02 >> (8 * i)) : 8'h04;
            wt(3);
            chk(32'({tsig, tins}), (i < 2) ? 32'h2 : (i < 4) ? 32'h1 : 32'h0);
        end
        $display("test status done");
        end_of_test();
    end
endmodule : tb_udf_top

// [tb/udf_contacts.sv]
`timescale 1ns/1ns
// operator switches wired to the contact terminals
module udf_contacts (
    // clock
    input  wire logic clk,
    // operator commands
    input  wire logic up_cmd,
    input  wire logic down_cmd,
    input  wire logic clear_cmd,
    input  wire logic stop_cmd,
    input  wire logic power_cmd,
    // contact terminals and supply sense line, open at power-up
    output logic      up_contact = 1'b0,
    output logic      down_contact = 1'b0,
    output logic      clear_contact = 1'b0,
    output logic      stop_contact = 1'b0,
    output logic      power_contact = 1'b0
);
    // one cycle of travel; no bounce, the pin sync would not hide it
    always_ff @(posedge clk) begin
        up_contact    <= up_cmd;
        down_contact  <= down_cmd;
        clear_contact <= clear_cmd;
        stop_contact  <= stop_cmd;
        power_contact <= power_cmd;
    end
endmodule : udf_contacts
